// ---- tio_pkg.sv ----
package tio_pkg;
  // Channel count and counter width
  localparam int NUM_CH = 5;
  localparam int CNT_W = 16;
  // Register groups; channel n sits at group base + n
  localparam logic [7:0] OFS_PIN_CTL = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h08;
  localparam logic [7:0] OFS_IRQ_EN = 8'h10;
  localparam logic [7:0] OFS_GROUP_MASK = 8'hf8;
  // Values after reset or standby
  localparam logic [7:0] PIN_CTL_RESET = 8'h88;
  localparam logic [7:0] FLAGS_RESET = 8'hf8;
  localparam logic [7:0] IRQ_EN_RESET = 8'hf8;
  // Bits that are stuck at one
  localparam logic [7:0] PIN_CTL_ONES = 8'h88;
  localparam logic [7:0] FLAGS_ONES = 8'hf8;
  localparam logic [7:0] IRQ_EN_ONES = 8'hf8;
  // Field positions
  localparam int FLD_A_LSB = 0;
  localparam int FLD_B_LSB = 4;
  localparam int FLD_W = 3;
  localparam int BIT_FLAG_A = 0;
  localparam int BIT_FLAG_B = 1;
  localparam int BIT_WRAP = 2;
  // Function codes of a side
  localparam logic [2:0] OC_NONE = 3'h0;
  localparam logic [2:0] OC_LOW = 3'h1;
  localparam logic [2:0] OC_HIGH = 3'h2;
  localparam logic [2:0] OC_TOGGLE = 3'h3;
  localparam logic [2:0] IC_RISE = 3'h4;
  localparam logic [2:0] IC_FALL = 3'h5;
  // Channels with special behaviour
  localparam int CH_NO_TOGGLE = 2;
  localparam int CH_PHASE = 2;
  localparam int CH_PWM_FIRST = 3;
endpackage

// ---- tio_timer_io.sv ----
`timescale 1ns/1ps
// What this block does
// R01 - Five channels, each with its own identical control and flag register.
// R02 - Control register loads 0x88 on reset and standby entry.
// R03 - Control bits 7 and 3 ignore writes and read as one.
// R04 - Bits 6..4 set side B; top bit zero compare, one capture.
// R05 - Bits 2..0 set side A with the same coding, driving pin A.
// R06 - Compare codes 0..3: nothing, drive low, drive high, toggle on match.
// R07 - Channel 2 toggle code drives high instead of toggling.
// R08 - Compare pins stay low after reset until the first match.
// R09 - Capture codes: 4 rising, 5 falling, 6 or 7 both edges.
// R10 - Channels 3 and 4 ignore control settings in the paired PWM modes.
// R11 - Flag register loads 0xf8 on reset and standby entry.
// R12 - Flag register bits 7..3 ignore writes and read as one.
// R13 - Wrap flag sets on counter overflow or underflow.
// R14 - Underflow only counts in channel 2 phase mode or 3/4 complementary PWM.
// R15 - A flag clears only by reading it as one then writing zero.
// R16 - Writing one to a flag does nothing.
// R17 - Flag B sets on counter equal to register B in compare mode.
// R18 - Flag B sets when a capture loads register B.
// R19 - Flag A sets on compare match or capture of register A.
// R20 - Each flag requests an interrupt only when its enable is set.
// R21 - Enable register holds wrap, B and A enables in bits 2..0, reset off.
// R22 - A set and a clear of a flag in one cycle leave it set.
// R23 - A side in capture mode leaves its pin undriven.
module tio_timer_io #(
  parameter int NCH = tio_pkg::NUM_CH,
  parameter int CW = tio_pkg::CNT_W
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  // Operating modes
  input wire logic standby_in,
  input wire logic phase_count_select_in,
  input wire logic complementary_pwm_in,
  input wire logic reset_sync_pwm_in,
  // Counter and general registers
  input wire logic [NCH*CW-1:0] timer_count_value_in,
  input wire logic [NCH*CW-1:0] general_register_a_in,
  input wire logic [NCH*CW-1:0] general_register_b_in,
  input wire logic [NCH-1:0] count_wrap_up_in,
  input wire logic [NCH-1:0] count_wrap_down_in,
  output logic [NCH-1:0] capture_a_out,
  output logic [NCH-1:0] capture_b_out,
  // Timer pins
  input wire logic [NCH-1:0] a_side_timer_pin_in,
  input wire logic [NCH-1:0] b_side_timer_pin_in,
  output logic [NCH-1:0] a_side_timer_pin_out,
  output logic [NCH-1:0] a_side_timer_pin_oe_out,
  output logic [NCH-1:0] b_side_timer_pin_out,
  output logic [NCH-1:0] b_side_timer_pin_oe_out,
  // Interrupt requests
  output logic [NCH-1:0] irq_wrap_out,
  output logic [NCH-1:0] irq_b_out,
  output logic [NCH-1:0] irq_a_out
);

  initial begin
    if (NCH != tio_pkg::NUM_CH || CW != tio_pkg::CNT_W) begin
      $error("tio_timer_io supports only the documented channel count and width");
    end
  end

  // Address decode
  wire [2:0] ch_sel_w = addr_in[2:0];
  wire [7:0] grp_w = addr_in & tio_pkg::OFS_GROUP_MASK;
  wire ch_ok_w = 32'(ch_sel_w) < NCH;
  wire hit_ctl_w = ch_ok_w && (grp_w == tio_pkg::OFS_PIN_CTL);
  wire hit_flg_w = ch_ok_w && (grp_w == tio_pkg::OFS_FLAGS);
  wire hit_ien_w = ch_ok_w && (grp_w == tio_pkg::OFS_IRQ_EN);
  wire pwm34_w = complementary_pwm_in || reset_sync_pwm_in;

  wire [7:0] ctl_rd_w [NCH];
  wire [7:0] flg_rd_w [NCH];
  wire [7:0] ien_rd_w [NCH];
  wire [2:0] set_w [NCH];
  wire [2:0] eff_w [NCH][2];
  wire match_w [NCH][2];

  wire [7:0] rd_val_w = hit_ctl_w ? ctl_rd_w[ch_sel_w] :
                        hit_flg_w ? flg_rd_w[ch_sel_w] :
                        hit_ien_w ? ien_rd_w[ch_sel_w] : 8'h00;

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= rd_in ? rd_val_w : 8'h00;
    end
  end

  for (genvar i = 0; i < NCH; i++) begin : g_ch
    logic [7:0] ctl_r;
    logic [2:0] flag_r;
    logic [2:0] arm_r;
    logic [2:0] ien_r;
    logic [2:0] flag_nxt;
    wire wr_ctl_w = wr_in && hit_ctl_w && (32'(ch_sel_w) == i);
    wire wr_flg_w = wr_in && hit_flg_w && (32'(ch_sel_w) == i);
    wire rd_flg_w = rd_in && hit_flg_w && (32'(ch_sel_w) == i);
    wire wr_ien_w = wr_in && hit_ien_w && (32'(ch_sel_w) == i);
    wire under_ok_w = (i == tio_pkg::CH_PHASE && phase_count_select_in) ||
                      (i >= tio_pkg::CH_PWM_FIRST && complementary_pwm_in);
    wire wrap_ev_w = count_wrap_up_in[i] || (count_wrap_down_in[i] && under_ok_w); // R13 R14
    wire [2:0] clr_w = wr_flg_w ? (arm_r & ~wdata_in[2:0]) : 3'h0; // R15 R16
    wire [CW-1:0] cnt_w = timer_count_value_in[i*CW +: CW];
    wire [CW-1:0] gr_w [2];
    wire pin_in_w [2];
    wire cap_w [2];
    logic pin_r [2];
    logic oe_r [2];

    assign gr_w[0] = general_register_a_in[i*CW +: CW];
    assign gr_w[1] = general_register_b_in[i*CW +: CW];
    assign pin_in_w[0] = a_side_timer_pin_in[i];
    assign pin_in_w[1] = b_side_timer_pin_in[i];
    assign set_w[i] = {wrap_ev_w, match_w[i][1] || cap_w[1], match_w[i][0] || cap_w[0]}; // R17 R18 R19
    assign flag_nxt = (flag_r & ~clr_w) | set_w[i]; // R22
    assign ctl_rd_w[i] = ctl_r | tio_pkg::PIN_CTL_ONES; // R03
    assign flg_rd_w[i] = {5'h1f, flag_r} | tio_pkg::FLAGS_ONES; // R12
    assign ien_rd_w[i] = {5'h1f, ien_r} | tio_pkg::IRQ_EN_ONES;
    assign a_side_timer_pin_out[i] = pin_r[0];
    assign a_side_timer_pin_oe_out[i] = oe_r[0];
    assign b_side_timer_pin_out[i] = pin_r[1];
    assign b_side_timer_pin_oe_out[i] = oe_r[1];

    // Registers of one channel
    always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
        ctl_r <= tio_pkg::PIN_CTL_RESET;
        flag_r <= tio_pkg::FLAGS_RESET[2:0];
        arm_r <= 3'h0;
        ien_r <= tio_pkg::IRQ_EN_RESET[2:0];
      end else if (standby_in) begin
        ctl_r <= tio_pkg::PIN_CTL_RESET; // R02
        flag_r <= tio_pkg::FLAGS_RESET[2:0]; // R11
        arm_r <= 3'h0;
        ien_r <= tio_pkg::IRQ_EN_RESET[2:0]; // R21
      end else begin
        if (wr_ctl_w) begin
          ctl_r <= wdata_in | tio_pkg::PIN_CTL_ONES; // R01 R03
        end
        if (wr_ien_w) begin
          ien_r <= wdata_in[2:0]; // R21
        end
        flag_r <= flag_nxt;
        // Arm the flags seen as one; any write to the register ends the sequence
        if (rd_flg_w) begin
          arm_r <= flag_r; // R15
        end else if (wr_flg_w) begin
          arm_r <= 3'h0;
        end
      end
    end

    // Interrupt requests gated by the enables
    always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
        irq_wrap_out[i] <= 1'b0;
        irq_b_out[i] <= 1'b0;
        irq_a_out[i] <= 1'b0;
      end else begin
        irq_wrap_out[i] <= flag_r[tio_pkg::BIT_WRAP] && ien_r[tio_pkg::BIT_WRAP]; // R20
        irq_b_out[i] <= flag_r[tio_pkg::BIT_FLAG_B] && ien_r[tio_pkg::BIT_FLAG_B]; // R20
        irq_a_out[i] <= flag_r[tio_pkg::BIT_FLAG_A] && ien_r[tio_pkg::BIT_FLAG_A]; // R20
      end
    end

    // Side 0 is A, side 1 is B
    for (genvar s = 0; s < 2; s++) begin : g_side
      logic sync1_r;
      logic sync2_r;
      logic prev_r;
      logic eq_prev_r;
      logic cap_r;
      logic pin_nxt;
      wire [2:0] fld_w = (s == 0) ? ctl_r[tio_pkg::FLD_A_LSB +: tio_pkg::FLD_W] :
                                    ctl_r[tio_pkg::FLD_B_LSB +: tio_pkg::FLD_W]; // R04 R05
      wire eq_w = (cnt_w == gr_w[s]);
      wire rise_w = sync2_r && !prev_r;
      wire fall_w = !sync2_r && prev_r;

      assign eff_w[i][s] = (i >= tio_pkg::CH_PWM_FIRST && pwm34_w) ? tio_pkg::OC_NONE : fld_w; // R10
      assign match_w[i][s] = eq_w && !eq_prev_r && !eff_w[i][s][2]; // R17 R19
      assign cap_w[s] = (eff_w[i][s] == tio_pkg::IC_RISE) ? rise_w :
                        (eff_w[i][s] == tio_pkg::IC_FALL) ? fall_w :
                        (eff_w[i][s][2] && (rise_w || fall_w)); // R09

      always_comb begin
        pin_nxt = pin_r[s];
        if (match_w[i][s]) begin
          case (eff_w[i][s])
            tio_pkg::OC_LOW: pin_nxt = 1'b0; // R06
            tio_pkg::OC_HIGH: pin_nxt = 1'b1; // R06
            tio_pkg::OC_TOGGLE: pin_nxt = (i == tio_pkg::CH_NO_TOGGLE) ? 1'b1 : !pin_r[s]; // R06 R07
            default: pin_nxt = pin_r[s];
          endcase
        end
      end

      always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
          sync1_r <= 1'b0;
          sync2_r <= 1'b0;
          prev_r <= 1'b0;
          eq_prev_r <= 1'b0;
          cap_r <= 1'b0;
          pin_r[s] <= 1'b0;
          oe_r[s] <= 1'b0;
        end else begin
          sync1_r <= pin_in_w[s];
          sync2_r <= sync1_r;
          prev_r <= sync2_r;
          eq_prev_r <= eq_w;
          cap_r <= cap_w[s];
          pin_r[s] <= standby_in ? 1'b0 : pin_nxt; // R08
          oe_r[s] <= !eff_w[i][s][2] && (eff_w[i][s][1:0] != 2'h0); // R23
        end
      end
    end

    assign capture_a_out[i] = g_side[0].cap_r;
    assign capture_b_out[i] = g_side[1].cap_r;
  end

  // Checks on channels 0, 1, 2 and 3
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  wire rd_flg0_w = rd_in && hit_flg_w && (ch_sel_w == 3'h0);
  wire wr_flg0_w = wr_in && hit_flg_w && (ch_sel_w == 3'h0);
  wire rd_ctl_w = rd_in && hit_ctl_w;
  wire hit_any_w = hit_ctl_w || hit_flg_w || hit_ien_w;

  sequence s_read_armed;
    rd_flg0_w && g_ch[0].flag_r[0];
  endsequence
  sequence s_write_zero;
    wr_flg0_w && !wdata_in[0] && !set_w[0][0] && !standby_in;
  endsequence
  // Software may leave idle cycles between the read and the write
  sequence s_idle_gap;
    !wr_flg0_w;
  endsequence
  sequence s_rise_b1;
    g_ch[1].g_side[1].rise_w && eff_w[1][1] == tio_pkg::IC_RISE && !standby_in;
  endsequence

  a_ctl_fixed_ones: assert property (rd_ctl_w |=> rdata_out[7] && rdata_out[3]) // R03
    else $error("control reserved bits not read as one");
  a_flag_fixed_ones: assert property (rd_in && hit_flg_w |=> rdata_out[7:3] == 5'h1f) // R12
    else $error("flag reserved bits not read as one");
  a_standby_ctl: assert property (standby_in |=> g_ch[0].ctl_r == tio_pkg::PIN_CTL_RESET) // R02
    else $error("control not reloaded in standby");
  a_standby_flags: assert property (standby_in && !set_w[0][0] |=> !g_ch[0].flag_r[0]) // R11
    else $error("flags not reloaded in standby");
  a_set_wins: assert property (set_w[0][0] && !standby_in |=> g_ch[0].flag_r[0]) // R22
    else $error("flag set lost");
  a_clear_sequence: assert property (s_read_armed ##1 s_write_zero |=> !g_ch[0].flag_r[0]) // R15
    else $error("flag not cleared after read then write zero");
  a_clear_unarmed: assert property (wr_flg0_w && !g_ch[0].arm_r[0] && g_ch[0].flag_r[0] && !standby_in // R15
    |=> g_ch[0].flag_r[0])
    else $error("flag cleared without prior read");
  a_write_one: assert property (wr_flg0_w && wdata_in[0] && !g_ch[0].flag_r[0] && !set_w[0][0] // R16
    |=> !g_ch[0].flag_r[0])
    else $error("writing one set a flag");
  a_no_toggle_ch2: assert property (match_w[2][0] && eff_w[2][0] == tio_pkg::OC_TOGGLE && !standby_in // R07
    |=> a_side_timer_pin_out[2] ##1 a_side_timer_pin_out[2] || match_w[2][0])
    else $error("channel 2 toggled");
  a_capture_undriven: assert property (eff_w[1][1][2] |=> !b_side_timer_pin_oe_out[1]) // R23
    else $error("capture side pin driven");
  a_capture_a_undriven: assert property (eff_w[1][0][2] |=> !a_side_timer_pin_oe_out[1]) // R23
    else $error("capture side A pin driven");
  a_underflow_gate: assert property (count_wrap_down_in[0] && !count_wrap_up_in[0] |-> !set_w[0][2]) // R14
    else $error("underflow counted on channel 0");
  a_irq_gate: assert property (!g_ch[0].ien_r[0] |=> !irq_a_out[0]) // R20
    else $error("interrupt without enable");
  a_irq_follows: assert property (g_ch[0].flag_r[0] && g_ch[0].ien_r[0] |=> irq_a_out[0]) // R20
    else $error("enabled flag gave no interrupt");

  // Register port
  a_clear_after_gap: assert property (s_read_armed ##1 s_idle_gap ##1 s_write_zero // R15
    |=> !g_ch[0].flag_r[0])
    else $error("flag not cleared after read, idle cycle, write zero");
  a_rdata_idle: assert property (!rd_in |=> rdata_out == 8'h00) // R01
    else $error("read data without a read");
  a_unmapped_read: assert property (rd_in && !hit_any_w |=> rdata_out == 8'h00) // R01
    else $error("unmapped address read not zero");
  a_ien_fixed_ones: assert property (rd_in && hit_ien_w |=> rdata_out[7:3] == 5'h1f) // R21
    else $error("enable reserved bits not read as one");
  a_ctl_write: assert property (wr_in && hit_ctl_w && ch_sel_w == 3'h0 && !standby_in // R03
    |=> g_ch[0].ctl_r == ($past(wdata_in) | tio_pkg::PIN_CTL_ONES))
    else $error("control write not stored");

  // Standby
  a_standby_ien: assert property (standby_in |=> g_ch[0].ien_r == 3'h0) // R21
    else $error("enables not reloaded in standby");
  a_standby_pin: assert property (standby_in |=> !a_side_timer_pin_out[0] && !b_side_timer_pin_out[0]) // R08
    else $error("pin not low in standby");

  // Compare pins
  a_drive_low: assert property (match_w[0][0] && eff_w[0][0] == tio_pkg::OC_LOW && !standby_in // R06
    |=> !a_side_timer_pin_out[0])
    else $error("compare did not drive low");
  a_drive_high: assert property (match_w[0][0] && eff_w[0][0] == tio_pkg::OC_HIGH && !standby_in // R06
    |=> a_side_timer_pin_out[0])
    else $error("compare did not drive high");
  a_toggle_ch0: assert property (match_w[0][0] && eff_w[0][0] == tio_pkg::OC_TOGGLE && !standby_in // R06
    |=> a_side_timer_pin_out[0] != $past(a_side_timer_pin_out[0]))
    else $error("compare did not toggle");
  a_oe_compare: assert property (eff_w[0][0] == tio_pkg::OC_HIGH |=> a_side_timer_pin_oe_out[0]) // R05
    else $error("compare pin not driven");
  a_pwm_ignored: assert property (complementary_pwm_in || reset_sync_pwm_in // R10
    |=> !a_side_timer_pin_oe_out[3] && !b_side_timer_pin_oe_out[3])
    else $error("control obeyed in paired PWM mode");

  // Flags and captures
  a_wrap_up_sets: assert property (count_wrap_up_in[0] && !standby_in |=> g_ch[0].flag_r[2]) // R13
    else $error("overflow not flagged");
  a_under_ch2: assert property (count_wrap_down_in[2] && phase_count_select_in && !standby_in // R14
    |=> g_ch[2].flag_r[2])
    else $error("channel 2 underflow not flagged");
  a_under_ch3: assert property (count_wrap_down_in[3] && complementary_pwm_in && !standby_in // R14
    |=> g_ch[3].flag_r[2])
    else $error("channel 3 underflow not flagged");
  a_match_b_flag: assert property (match_w[0][1] && !standby_in |=> g_ch[0].flag_r[1]) // R17
    else $error("compare B not flagged");
  a_capture_b_flag: assert property (s_rise_b1 |=> g_ch[1].flag_r[1] && capture_b_out[1]) // R18
    else $error("capture B not flagged");
  a_fall_capture: assert property (g_ch[1].g_side[1].fall_w && eff_w[1][1] == tio_pkg::IC_FALL && !standby_in // R09
    |=> g_ch[1].flag_r[1])
    else $error("falling capture missed");
  a_capture_a_pulse: assert property (g_ch[1].g_side[0].rise_w && eff_w[1][0] == tio_pkg::IC_RISE // R19
    |=> capture_a_out[1])
    else $error("capture A pulse missed");

endmodule

// ---- tio_far_end.sv ----
`timescale 1ns/1ps
module tio_far_end (
  // Clock
  input wire logic mclk_in,
  // Count control
  input wire logic load_in,
  input wire logic [15:0] load_val_in,
  input wire logic down_in,
  // Count and wrap pulses, same for every channel
  output logic [79:0] cnt_out,
  output logic [4:0] up_wrap_out,
  output logic [4:0] down_wrap_out
);
  logic [15:0] c_r;
  logic [15:0] c_nxt;
  assign c_nxt = load_in ? load_val_in : (down_in ? c_r - 16'h1 : c_r + 16'h1);
  assign cnt_out = {5{c_r}};
  always_ff @(posedge mclk_in) begin
    c_r <= c_nxt;
    up_wrap_out <= {5{!load_in && !down_in && c_r == 16'hffff}};
    down_wrap_out <= {5{!load_in && down_in && c_r == 16'h0000}};
  end
endmodule

// ---- timer_io_control_and_status_bench.sv ----
`timescale 1ns/1ps
module timer_io_control_and_status_bench;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic stby = 1'b0;
  logic pcs = 1'b0;
  logic cpwm = 1'b0;
  logic ld = 1'b1;
  logic dn = 1'b0;
  logic [15:0] ldv = 16'h0200;
  logic [4:0] ext_b = 5'h00;
  logic [7:0] rdata;
  logic [79:0] cnt;
  logic [4:0] upw, dnw, cap_a, cap_b, pa, pa_oe, pb, pb_oe, irq_w, irq_b, irq_a, pin_b;
  logic [7:0] exp_q[$];
  logic [7:0] rv;
  logic rd_d = 1'b0;
  int fail_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int ncap = 0;
  int chs[9] = '{0, 0, 0, 0, 0, 2, 2, 3, 4};
  logic [2:0] codes[9] = '{3'h2, 3'h3, 3'h3, 3'h1, 3'h0, 3'h2, 3'h3, 3'h2, 3'h2};
  logic pins[9] = '{1, 0, 1, 0, 0, 1, 1, 0, 1};
  logic [2:0] ccode[7] = '{3'h4, 3'h4, 3'h5, 3'h5, 3'h6, 3'h6, 3'h7};
  logic clev[7] = '{1, 0, 1, 0, 1, 0, 1};
  logic cset[7] = '{1, 0, 0, 1, 1, 1, 1};
  // Pin B is a two-way wire: design level when enabled, outside level otherwise
  assign pin_b = (pb_oe & pb) | (~pb_oe & ext_b);
  initial begin
    forever #2.5 mclk_in = ~mclk_in;
  end
  tio_far_end i_tio_far_end (.mclk_in(mclk_in), .load_in(ld), .load_val_in(ldv), .down_in(dn),
    .cnt_out(cnt), .up_wrap_out(upw), .down_wrap_out(dnw));
  tio_timer_io i_tio_timer_io (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .standby_in(stby), .phase_count_select_in(pcs),
    .complementary_pwm_in(cpwm), .reset_sync_pwm_in(1'b0), .timer_count_value_in(cnt),
    .general_register_a_in({5{16'h0100}}), .general_register_b_in({5{16'h8000}}),
    .count_wrap_up_in(upw), .count_wrap_down_in(dnw), .capture_a_out(cap_a), .capture_b_out(cap_b),
    .a_side_timer_pin_in(ext_b), .b_side_timer_pin_in(pin_b), .a_side_timer_pin_out(pa),
    .a_side_timer_pin_oe_out(pa_oe), .b_side_timer_pin_out(pb), .b_side_timer_pin_oe_out(pb_oe),
    .irq_wrap_out(irq_w), .irq_b_out(irq_b), .irq_a_out(irq_a));
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_in);
    wr <= 1'b0;
  endtask
  task automatic rd8(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_in);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge mclk_in);
    rd <= 1'b0;
  endtask
  task automatic load(input logic [15:0] v);
    @(posedge mclk_in);
    ldv <= v;
    ld <= 1'b1;
    @(posedge mclk_in);
    ld <= 1'b0;
  endtask
  task automatic clr(input logic [7:0] f, input logic [7:0] e);
    wr8(f, 8'h00);
    rd8(f, e);
    wr8(f, 8'hff);
    rd8(f, e);
    wr8(f, 8'hf8);
    rd8(f, 8'hf8);
    wr8(f, 8'hff);
    rd8(f, 8'hf8);
  endtask
  // Read data is judged in the cycle after the strobe
  always @(posedge mclk_in) begin
    if (rd_d) chk(rdata, exp_q.pop_front());
    rd_d <= rd;
    if (cap_b[1] === 1'b1) ncap++;
    if (cap_a[1] === 1'b1) ncap++;
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(32'he9e0531b));
    tick(5);
    rst_in <= 1'b0;
    ld <= 1'b0;
    chk({3'h0, pa}, 8'h00);
    for (int c = 0; c < 5; c++) begin
      rd8(c[7:0], 8'h88);
      rd8(8'h08 + c[7:0], 8'hf8);
      rd8(8'h10 + c[7:0], 8'hf8);
    end
    rd8(8'h05, 8'h00);
    wr8(8'h00, 8'h77);
    rd8(8'h00, 8'hff);
    rv = $urandom;
    wr8(8'h01, rv);
    rd8(8'h01, rv | 8'h88);
    wr8(8'h01, 8'h00);
    wr8(8'h08, 8'h00);
    rd8(8'h08, 8'hf8);
    wr8(8'h10, 8'h01);
    rd8(8'h10, 8'hf9);
    for (int i = 0; i < 9; i++) begin
      cpwm <= (chs[i] == 3);
      wr8(chs[i][7:0], {5'h00, codes[i]});
      load(16'h00fa);
      tick(12);
      chk({7'h0, pa[chs[i]]}, {7'h0, pins[i]});
      chk({7'h0, pa_oe[chs[i]]}, {7'h0, codes[i] != 3'h0 && chs[i] != 3});
      chk({7'h0, irq_a[chs[i]]}, {7'h0, chs[i] == 0});
      clr(8'h08 + chs[i][7:0], 8'hf9);
    end
    for (int i = 0; i < 7; i++) begin
      wr8(8'h01, {1'b0, ccode[i], 1'b0, ccode[i]});
      ext_b[1] <= clev[i];
      tick(8);
      chk({7'h0, pb_oe[1]}, 8'h00);
      rd8(8'h09, {6'h3e, cset[i], 1'b1});
      wr8(8'h09, 8'hfd);
    end
    pcs <= 1'b1;
    cpwm <= 1'b1;
    dn <= 1'b1;
    load(16'h0002);
    tick(6);
    rd8(8'h08, 8'hf9);
    rd8(8'h0a, 8'hfd);
    rd8(8'h0b, 8'hfd);
    dn <= 1'b0;
    load(16'hfffe);
    tick(6);
    rd8(8'h08, 8'hfd);
    wr8(8'h12, 8'h06);
    tick(2);
    chk({3'h0, irq_w}, 8'h04);
    chk({3'h0, irq_b}, 8'h00);
    chk({3'h0, irq_a}, 8'h01);
    wr8(8'h00, 8'h20);
    load(16'h7ffa);
    tick(12);
    chk({3'h0, pb}, 8'h01);
    chk({3'h0, pb_oe}, 8'h01);
    rd8(8'h08, 8'hff);
    stby <= 1'b1;
    tick(2);
    stby <= 1'b0;
    rd8(8'h02, 8'h88);
    rd8(8'h0a, 8'hf8);
    rd8(8'h10, 8'hf8);
    chk({3'h0, pa}, 8'h00);
    tick(4);
    chk(ncap[7:0], 8'h0a);
    end_of_test();
  end
endmodule
